// ===== rtl/exec_map.svh
// Purpose: Constants for the compare/skip, BCD adjust and decrement slice
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data address
// Notes:
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OPC_INVERT   6'h07
`define OPC_DECR     6'h01
`define OPC_SKIP_LT  7'h30
`define OPC_SKIP_EQ  7'h31
`define OPC_SKIP_GT  7'h32
`define OPC_BCD      16'h0007
`define NOP_WORD     16'h0000
`define OPC_TWO_A    4'hC
`define OPC_TWO_B    6'h3B
`define BIT_DEST     9
`define BIT_ACCESS   8
`define ACC_LO_BANK  4'h0
`define ACC_HI_BANK  4'hF
`define F_C          0
`define F_DC         1
`define F_Z          2
`define F_OV         3
`define F_N          4
`define NIB_LIMIT    4'h9
`define BCD_STEP     4'h6
`define OV_EDGE      8'h80
`define REG_ACC      2'h0
`define REG_STATUS   2'h1
`define REG_BANK     2'h2
`define RST_BYTE     8'h00
`define RST_STATUS   5'h00
`define RST_BANK     4'h0
`endif

// ===== rtl/exec_pkg.sv
// Purpose: Types for the execution slice
// Assumes: One instruction cycle is four quarter phases
// Notes: Phase codes are one-hot
package exec_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_t;
  typedef logic [4:0] status_t;
endpackage : exec_pkg

// ===== rtl/compare_skip_bcd_decrement_exec.sv
// Purpose: Executes invert, decrement, BCD adjust and the three compare-and-skip ops
// Assumes: Fetch presents the next word while instr_take is high; file memory reads combinationally
// Notes: Bus writes win over a same-cycle core write to the accumulator or status
`timescale 1ns/10ps
`include "exec_map.svh"
module compare_skip_bcd_decrement_exec (
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  input  wire logic [15:0]    instr_word,
  output logic                instr_take,
  output logic                pc_advance,
  output logic                discard_cycle,
  output exec_pkg::phase_t    phase,
  output logic [11:0]         file_addr,
  input  wire logic [7:0]     file_rdata,
  output logic [7:0]          file_wdata,
  output logic                file_we,
  input  wire logic [1:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [7:0]          reg_rdata
);
  import exec_pkg::*;

  phase_t      ph_q;
  phase_t      ph_d;
  logic [15:0] ir_q;
  logic        skip_q;
  logic        discard_q;
  logic        hit_q;
  logic [7:0]  acc_q;
  logic [7:0]  opnd_q;
  logic [7:0]  res_q;
  logic [7:0]  rdata_q;
  logic [3:0]  bank_q;
  status_t     stat_q;
  status_t     flag_q;
  status_t     flag_d;

  // Decode of the latched word
  wire is_inv  = ir_q[15:10] == `OPC_INVERT;
  wire is_dec  = ir_q[15:10] == `OPC_DECR;
  wire is_clt  = ir_q[15:9] == `OPC_SKIP_LT;
  wire is_ceq  = ir_q[15:9] == `OPC_SKIP_EQ;
  wire is_cgt  = ir_q[15:9] == `OPC_SKIP_GT;
  wire is_bcd  = ir_q == `OPC_BCD;
  wire is_cmp  = is_clt | is_ceq | is_cgt;
  wire is_alu  = is_inv | is_dec;
  wire to_file = ir_q[`BIT_DEST];
  wire use_bank = ir_q[`BIT_ACCESS];

  // A word that owns a second word must be discarded along with it
  wire two_word = (instr_word[15:12] == `OPC_TWO_A) | (instr_word[15:10] == `OPC_TWO_B);

  wire in_q1 = clk_en & (ph_q == PH_Q1);
  wire in_q2 = clk_en & (ph_q == PH_Q2);
  wire in_q3 = clk_en & (ph_q == PH_Q3);
  wire in_q4 = clk_en & (ph_q == PH_Q4);

  // Low half of the access bank maps to bank 0, upper half to the top bank
  wire [3:0] acc_bank = ir_q[7] ? `ACC_HI_BANK : `ACC_LO_BANK;
  assign file_addr = use_bank ? {bank_q, ir_q[7:0]} : {acc_bank, ir_q[7:0]};

  // Unsigned compare by subtraction
  wire [8:0] diff  = {1'b0, opnd_q} - {1'b0, acc_q};
  wire       f_eq  = diff[7:0] == 8'h00;
  wire       f_lt  = diff[8];
  wire       f_gt  = ~f_lt & ~f_eq;
  wire       hit_d = (is_ceq & f_eq) | (is_cgt & f_gt) | (is_clt & f_lt);

  // Invert and decrement results
  wire [7:0] inv_val = ~opnd_q;
  wire [7:0] dec_val = opnd_q - 8'h01;

  // Packed BCD correction
  wire       lo_adj  = (opnd_q[3:0] > `NIB_LIMIT) | stat_q[`F_DC];
  wire       hi_adj  = (opnd_q[7:4] > `NIB_LIMIT) | stat_q[`F_C];
  wire [3:0] lo_step = lo_adj ? `BCD_STEP : 4'h0;
  wire [3:0] hi_step = hi_adj ? `BCD_STEP : 4'h0;
  wire [4:0] lo_sum  = {1'b0, opnd_q[3:0]} + {1'b0, lo_step};
  wire [8:0] bcd_sum = {1'b0, opnd_q} + {1'b0, hi_step, lo_step};

  wire [7:0] res_d = is_inv ? inv_val : (is_dec ? dec_val : bcd_sum[7:0]);

  always_comb begin
    flag_d = stat_q;
    if (is_inv) begin
      flag_d[`F_N] = inv_val[7];
      flag_d[`F_Z] = inv_val == 8'h00;
    end else if (is_dec) begin
      flag_d[`F_C]  = opnd_q != 8'h00;
      flag_d[`F_DC] = opnd_q[3:0] != 4'h0;
      flag_d[`F_OV] = opnd_q == `OV_EDGE;
      flag_d[`F_N]  = dec_val[7];
      flag_d[`F_Z]  = dec_val == 8'h00;
    end else if (is_bcd) begin
      // A carry already out of the earlier add must survive the correction
      flag_d[`F_C]  = bcd_sum[8] | stat_q[`F_C];
      flag_d[`F_DC] = lo_sum[4];
    end
  end

  always_comb begin
    unique case (ph_q)
      PH_Q1: ph_d = PH_Q2;
      PH_Q2: ph_d = PH_Q3;
      PH_Q3: ph_d = PH_Q4;
      PH_Q4: ph_d = PH_Q1;
      default: ph_d = PH_Q1;
    endcase
  end

  // Bus decode
  wire wr_acc  = reg_wr & (reg_addr == `REG_ACC);
  wire wr_stat = reg_wr & (reg_addr == `REG_STATUS);
  wire wr_bank = reg_wr & (reg_addr == `REG_BANK);
  wire [7:0] rd_mux = (reg_addr == `REG_ACC) ? acc_q :
                      (reg_addr == `REG_STATUS) ? {3'h0, stat_q} :
                      (reg_addr == `REG_BANK) ? {4'h0, bank_q} : `RST_BYTE;

  // Core write-backs at the fourth quarter
  wire acc_we  = in_q4 & (is_bcd | (is_alu & ~to_file));
  wire stat_we = in_q4 & (is_alu | is_bcd);

  assign file_we       = in_q4 & is_alu & to_file;
  assign file_wdata    = res_q;
  assign instr_take    = in_q1;
  assign pc_advance    = in_q4;
  assign discard_cycle = discard_q;
  assign phase         = ph_q;
  assign reg_rdata     = rdata_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ph_q <= PH_Q1;
    end else if (clk_en) begin
      ph_q <= ph_d;
    end
  end

  // Skipped words enter as a no-op so none of their effects can occur
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ir_q      <= `NOP_WORD;
      discard_q <= 1'b0;
      skip_q    <= 1'b0;
    end else if (in_q1) begin
      ir_q      <= skip_q ? `NOP_WORD : instr_word;
      discard_q <= skip_q;
      skip_q    <= skip_q & two_word;
    end else if (in_q4) begin
      // A pair skip armed at this Q1 must survive into the next Q1
      skip_q    <= skip_q | hit_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      opnd_q <= `RST_BYTE;
    end else if (in_q2) begin
      opnd_q <= is_bcd ? acc_q : file_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_q  <= `RST_BYTE;
      flag_q <= `RST_STATUS;
      hit_q  <= 1'b0;
    end else if (in_q3) begin
      res_q  <= res_d;
      flag_q <= flag_d;
      hit_q  <= hit_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= `RST_BYTE;
    end else if (clk_en) begin
      if (wr_acc) begin
        acc_q <= reg_wdata;
      end else if (acc_we) begin
        acc_q <= res_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stat_q <= `RST_STATUS;
    end else if (clk_en) begin
      if (wr_stat) begin
        stat_q <= reg_wdata[4:0];
      end else if (stat_we) begin
        stat_q <= flag_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bank_q <= `RST_BANK;
    end else if (clk_en && wr_bank) begin
      bank_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= `RST_BYTE;
    end else if (clk_en && reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_equal_hit: assert property (in_q3 && is_ceq && opnd_q == acc_q |=> hit_q)
    else $error("equal compare did not flag a skip");
  a_greater_hit: assert property (in_q3 && is_cgt |=> hit_q == ($past(opnd_q) > $past(acc_q)))
    else $error("greater compare decision wrong");
  a_less_hit: assert property (in_q3 && is_clt |=> hit_q == ($past(opnd_q) < $past(acc_q)))
    else $error("less compare decision wrong");
  a_skip_arms: assert property (in_q4 && is_cmp && hit_q |=> skip_q)
    else $error("taken compare did not arm the skip");
  a_discard_nop: assert property (in_q1 && skip_q |=> ir_q == `NOP_WORD && discard_q)
    else $error("discarded word was not replaced by a no-op");
  a_two_word_skip: assert property (in_q1 && skip_q && two_word |=> skip_q)
    else $error("second word of a skipped pair not discarded");
  a_pair_hold: assert property (in_q4 && skip_q |=> skip_q)
    else $error("pending pair skip dropped at write-back");
  a_skip_ends: assert property (in_q1 && skip_q && !two_word |=> !skip_q)
    else $error("skip did not end after a single word");
  a_cmp_flags: assert property (in_q4 && is_cmp && !wr_stat |=> stat_q == $past(stat_q))
    else $error("compare changed a status flag");
  a_cmp_nowrite: assert property (is_cmp |-> !file_we && !acc_we)
    else $error("compare wrote a register");
  a_bank_addr: assert property (use_bank |-> file_addr[11:8] == bank_q)
    else $error("banked address ignored the bank pointer");
  a_invert_val: assert property (in_q3 && is_inv |=> res_q == ~$past(opnd_q))
    else $error("invert result wrong");
  a_decr_val: assert property (in_q3 && is_dec |=> res_q == $past(opnd_q) - 8'h01)
    else $error("decrement result wrong");
  a_decr_dest: assert property (file_we |-> ph_q == PH_Q4 && to_file && is_alu)
    else $error("file written outside a file-destination write-back");
  a_bcd_carry: assert property (in_q3 && is_bcd && hi_adj |=> flag_q[`F_C])
    else $error("BCD high correction left carry clear");
  a_bcd_low: assert property (in_q3 && is_bcd && !lo_adj && !hi_adj |=> res_q == $past(opnd_q))
    else $error("BCD adjust altered a valid byte");
  a_freeze_state: assert property (!clk_en |=> $stable(ph_q) && $stable(acc_q))
    else $error("state moved while clock enable was low");

  a_discard_quiet: assert property (discard_q |-> !file_we && !acc_we && !stat_we)
    else $error("discarded word caused a write");
  a_discard_pc: assert property (in_q4 && discard_q |-> pc_advance)
    else $error("discarded word did not advance the counter");
  a_cmp_noskip: assert property (in_q4 && is_cmp && !hit_q |=> !skip_q)
    else $error("failed compare armed a skip");
  a_acc_dest: assert property (in_q4 && is_alu && !to_file && !wr_acc |=> acc_q == $past(res_q))
    else $error("accumulator destination not written");
  a_access_low: assert property (!use_bank && !ir_q[7] |-> file_addr[11:8] == `ACC_LO_BANK)
    else $error("low access half mapped wrongly");
  a_access_high: assert property (!use_bank && ir_q[7] |-> file_addr[11:8] == `ACC_HI_BANK)
    else $error("high access half mapped wrongly");
  a_bcd_lo_step: assert property (in_q3 && is_bcd && lo_adj && !hi_adj |=>
    res_q[3:0] == $past(opnd_q[3:0]) + `BCD_STEP)
    else $error("BCD low nibble step wrong");
  a_bcd_hi_step: assert property (in_q3 && is_bcd && hi_adj && !lo_adj |=>
    res_q[7:4] == $past(opnd_q[7:4]) + `BCD_STEP)
    else $error("BCD high nibble step wrong");
  a_bcd_half: assert property (in_q3 && is_bcd && !lo_adj |=> !flag_q[`F_DC])
    else $error("BCD half-carry set without low correction");
  a_bcd_acc: assert property (in_q4 && is_bcd && !wr_acc |=> acc_q == $past(res_q))
    else $error("BCD result not written to accumulator");
  a_decr_zero: assert property (in_q3 && is_dec && opnd_q == 8'h01 |=> flag_q[`F_Z])
    else $error("decrement to zero left zero flag clear");
  a_decr_wrap: assert property (in_q3 && is_dec && opnd_q == `OV_EDGE |=> flag_q[`F_OV] && !flag_q[`F_N])
    else $error("decrement wrap flags wrong");
  a_decr_borrow: assert property (in_q3 && is_dec && opnd_q == 8'h00 |=> !flag_q[`F_C] && flag_q[`F_N])
    else $error("decrement borrow flags wrong");
  a_decr_half: assert property (in_q3 && is_dec && opnd_q[3:0] == 4'h0 |=> !flag_q[`F_DC])
    else $error("decrement half borrow wrong");
  a_invert_flag: assert property (in_q3 && is_inv |=> flag_q[`F_N] != $past(opnd_q[7]))
    else $error("invert negative flag wrong");
  a_take_gated: assert property (!clk_en |-> !instr_take && !pc_advance && !file_we)
    else $error("strobe raised while clock enable was low");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_stat_hold: assert property (in_q4 && !is_alu && !is_bcd && !wr_stat |=> $stable(stat_q))
    else $error("status moved on a flagless instruction");

  c_skip_taken: cover property (in_q4 && is_cmp && hit_q);
  c_skip_pair: cover property (in_q1 && skip_q && two_word);
  c_bcd_run: cover property (in_q4 && is_bcd);
  c_decr_file: cover property (file_we && is_dec);
  c_freeze_hold: cover property (!clk_en ##1 !clk_en);

endmodule : compare_skip_bcd_decrement_exec

// ===== sim/tb.sv
// Purpose: Self-checking bench for the compare/skip, BCD adjust and decrement slice
// Assumes: Bench drives instruction words, file read data and the register port directly
// Notes: Each instruction word is driven at the Q4-to-Q1 edge so it is taken in the following Q1 cycle
`timescale 1ns/10ps
module tb;
  import exec_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic        clk_en;
  logic [15:0] instr_word;
  logic        instr_take;
  logic        pc_advance;
  logic        discard_cycle;
  phase_t      phase;
  logic [11:0] file_addr;
  logic [7:0]  file_rdata;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [11:0] x_addr;
  logic [7:0]  x_wdata;
  logic        x_disc;
  logic        x_we;
  logic        x_pc;
  int          err_total;
  int          checks;
  logic [7:0]  ops [3];
  logic [7:0]  bcd_acc [4];
  logic [7:0]  bcd_st [4];
  logic [15:0] e;

  compare_skip_bcd_decrement_exec i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_word(instr_word),
    .instr_take(instr_take), .pc_advance(pc_advance), .discard_cycle(discard_cycle), .phase(phase),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  always #25 core_clk = ~core_clk;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    instr_word <= 16'h0000;
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr     <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    instr_word <= 16'h0000;
    reg_addr   <= a;
    reg_rd     <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, exp}, "register read");
  endtask : rdc

  // Runs one instruction cycle and captures the Q2 and Q4 views of the outputs
  task automatic exec(input logic [15:0] w, input logic [7:0] fv);
    do @(posedge core_clk); while (phase !== PH_Q4);
    instr_word <= w;
    file_rdata <= fv;
    @(posedge core_clk);
    #1;
    x_addr = file_addr;
    x_disc = discard_cycle;
    @(posedge core_clk);
    @(posedge core_clk);
    #1;
    x_we    = file_we;
    x_wdata = file_wdata;
    x_pc    = pc_advance;
  endtask : exec

  function automatic logic [15:0] bcd(input logic [7:0] a, input logic [7:0] s);
    logic [8:0] t;
    logic       h;
    t = {1'b0, a};
    h = 1'b0;
    if (a[3:0] > 4'h9 || s[1]) begin
      h = ({1'b0, a[3:0]} + 5'h06) > 5'h0F;
      t = t + 9'h006;
    end
    if (a[7:4] > 4'h9 || s[0]) t = t + 9'h060;
    return {s[7:2], h, t[8] | s[0], t[7:0]};
  endfunction : bcd

  function automatic logic [7:0] dec_st(input logic [7:0] v);
    logic [7:0] r;
    r = v - 8'h01;
    return {3'b000, r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
  endfunction : dec_st

  task automatic final_report;
    $display("comparisons %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  initial begin
    #250000;
    err_total++;
    final_report;
  end

  initial begin
    core_clk = 1'b0; rst_n = 1'b0; clk_en = 1'b1; instr_word = 16'h0000; file_rdata = 8'h00;
    reg_addr = 2'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; err_total = 0; checks = 0;
    ops = '{8'h60, 8'h62, 8'h64};
    bcd_acc = '{8'hA5, 8'hCE, 8'h11, 8'h95};
    bcd_st = '{8'h00, 8'h1C, 8'h02, 8'h01};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_invert;
    t_bcd;
    t_decr;
    t_compare;
    t_two_word;
    t_freeze;
    final_report;
  end

  task automatic t_regs;
    rdc(2'h0, 8'h00);
    rdc(2'h1, 8'h00);
    wr(2'h2, 8'h05);
    rdc(2'h2, 8'h05);
    wr(2'h3, 8'hAA);
    rdc(2'h3, 8'h00);
  endtask : t_regs

  task automatic t_invert;
    exec(16'h1C13, 8'h13);
    chk(x_addr, 12'h013, "invert access low");
    chk({11'h0, x_we}, 12'h000, "invert to acc write");
    rdc(2'h0, 8'hEC);
    exec(16'h1F22, 8'h3C);
    chk(x_addr, 12'h522, "invert banked addr");
    chk({3'h0, x_we, x_wdata}, 12'h1C3, "invert to file");
  endtask : t_invert

  task automatic t_bcd;
    foreach (bcd_st[i]) begin
      wr(2'h1, 8'h00);
      exec(16'h0400 | {8'h00, bcd_st[i]}, bcd_st[i]);
      wr(2'h0, bcd_acc[i]);
      wr(2'h1, bcd_st[i]);
      exec(16'h0007, 8'h00);
      e = bcd(bcd_acc[i], bcd_st[i]);
      rdc(2'h0, e[7:0]);
      rdc(2'h1, e[15:8]);
    end
  endtask : t_bcd

  task automatic t_decr;
    foreach (bcd_acc[i]) begin
      exec(16'h0480, bcd_acc[i] - 8'h95);
      chk(x_addr, 12'hF80, "access high half");
      rdc(2'h0, bcd_acc[i] - 8'h96);
      rdc(2'h1, dec_st(bcd_acc[i] - 8'h95));
    end
    exec(16'h0480, 8'h80);
    rdc(2'h0, 8'h7F);
    rdc(2'h1, dec_st(8'h80));
    exec(16'h0480, 8'h01);
    rdc(2'h1, dec_st(8'h01));
    exec(16'h0701, 8'h00);
    chk({x_addr[11:0]}, 12'h501, "decrement banked");
    chk({3'h0, x_we, x_wdata}, 12'h1FF, "decrement to file");
  endtask : t_decr

  task automatic t_compare;
    foreach (ops[k]) begin
      for (int j = 0; j < 3; j++) begin
        wr(2'h0, 8'h80);
        wr(2'h1, 8'h1F);
        exec({ops[k], 8'h90}, 8'h7F + j[7:0]);
        chk(x_addr, 12'hF90, "compare addr");
        chk({11'h0, x_we}, 12'h000, "compare writes nothing");
        e[0] = (k == 0 && j == 0) || (k == 1 && j == 1) || (k == 2 && j == 2);
        exec(16'h0610, 8'h55);
        chk({11'h0, x_disc}, {11'h0, e[0]}, "skip decision");
        chk({11'h0, x_we}, {11'h0, !e[0]}, "discarded write");
        chk({11'h0, x_pc}, 12'h001, "pc steps");
        rdc(2'h0, 8'h80);
        if (e[0]) rdc(2'h1, 8'h1F);
      end
    end
  endtask : t_compare

  task automatic t_two_word;
    wr(2'h0, 8'h80);
    exec(16'h6290, 8'h80);
    exec(16'hC123, 8'h00);
    chk({11'h0, x_disc}, 12'h001, "two-word first");
    exec(16'h0410, 8'h55);
    chk({10'h0, x_disc, x_we}, 12'h002, "two-word second");
    exec(16'h0410, 8'h55);
    chk({11'h0, x_disc}, 12'h000, "skip ends");
    rdc(2'h0, 8'h54);
  endtask : t_two_word

  // Clock enable low must freeze phase, strobes and refuse a bus write
  task automatic t_freeze;
    phase_t p;
    @(posedge core_clk);
    instr_word <= 16'h0000;
    clk_en     <= 1'b0;
    reg_addr   <= 2'h0;
    reg_wdata  <= 8'h3C;
    reg_wr     <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
    p = phase;
    repeat (4) @(posedge core_clk);
    #1;
    chk({8'h0, phase}, {8'h0, p}, "phase frozen");
    chk({10'h0, instr_take, pc_advance}, 12'h000, "strobes frozen");
    @(posedge core_clk);
    clk_en <= 1'b1;
    rdc(2'h0, 8'h54);
  endtask : t_freeze
endmodule : tb
